// [design/emif_ctl_pkg.sv]
package emif_ctl_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// control field positions
	localparam int CTRL_DIV_LSB  = 0; // 2 bits: 0 div1, 1 div2, 2 div4
	localparam int CTRL_SREF_BIT = 2;
	localparam int CTRL_GPO_BIT  = 3;
	localparam int CTRL_SDRAM_BIT = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// clock source codes from the straps
	localparam logic [1:0] SRC_EXT  = 2'h0;
	localparam logic [1:0] SRC_CPU4 = 2'h1;
	localparam logic [1:0] SRC_CPU6 = 2'h2;

	// memory types of the space being accessed
	typedef enum logic [1:0] {
		MEM_ASYNC = 2'b00,
		MEM_SDRAM = 2'b01,
		MEM_SYNC  = 2'b10
	} mem_type_t;

	// one access request from the interface engine
	typedef struct packed {
		logic      active;
		mem_type_t memType;
		logic      readSelect;
		logic      readStrobe;
		logic      outputStrobe;
		logic      writeStrobe;
	} access_t;

	// the three shared strobe pins, active low; their enable is strobeOe, not part of this type
	typedef struct packed {
		logic readPin;
		logic outputPin;
		logic writePin;
	} strobe_pins_t;

	typedef enum logic [1:0] {
		ARB_OWN   = 2'b00,
		ARB_DRAIN = 2'b01,
		ARB_HELD  = 2'b10
	} arb_state_t;

endpackage

// [design/clock_divider.sv]
`timescale 1ns/10ps
// enable-pulse divider: pulse every 1, 2 or 4 enables of the source rate
module clock_divider (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       srcTick,
	input  wire logic [1:0] divCode,
	output logic            divTick
);
	logic [1:0] count_q;
	logic [1:0] limit;
	logic       wrap;

	// limit by code; code 3 treated as divide by four
	assign limit = (divCode == 2'h0) ? 2'h0 : ((divCode == 2'h1) ? 2'h1 : 2'h3);
	assign wrap  = srcTick && (count_q >= limit);

	// count source ticks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_q <= 2'h0;
		end else if (wrap) begin
			count_q <= 2'h0;
		end else if (srcTick) begin
			count_q <= count_q + 2'h1;
		end
	end

	assign divTick = wrap;
endmodule

// [design/ext_mem_if_clock_strobe_arb.sv]
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module ext_mem_if_clock_strobe_arb (
	input  wire logic                       clock,
	input  wire logic                       resetn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// clocking
	input  wire logic [1:0]                 clockSelectStraps,
	input  wire logic                       extInputClock,
	input  wire logic                       cpuDiv4Tick,
	input  wire logic                       cpuDiv6Tick,
	output logic                            fullRateOutputClock,
	output logic                            dividedOutputClock,
	// access engine side
	input  wire emif_ctl_pkg::access_t      access,
	// arbitration
	input  wire logic                       holdReqIn,
	output logic                            holdAckOut,
	output logic                            busRequestOut,
	// pins
	output emif_ctl_pkg::strobe_pins_t      strobePins,
	output logic                            strobeOe,
	output logic                            sdramClockEnable,
	output logic                            sdramClockEnableOe
);
	////////////////////////////////////////////////////////////////////////////////
	// strap capture and source selection
	logic [1:0] clockSource_q;
	logic       strapTaken_q;
	logic       extPrev_q;
	logic       extTick;
	logic       srcTick;
	logic       divTick;

	// straps caught once, at the first edge after release
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			clockSource_q <= emif_ctl_pkg::SRC_EXT;
			strapTaken_q  <= 1'b0;
		end else if (!strapTaken_q) begin
			strapTaken_q  <= 1'b1;
			clockSource_q <= (clockSelectStraps == emif_ctl_pkg::SRC_CPU4 ||
			                  clockSelectStraps == emif_ctl_pkg::SRC_CPU6) ?
			                 clockSelectStraps : emif_ctl_pkg::SRC_EXT;
		end
	end

	// external clock treated as synchronous input; both edges tick, so the
	// full rate output reproduces the input frequency rather than half of it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			extPrev_q <= 1'b0;
		end else begin
			extPrev_q <= extInputClock;
		end
	end
	assign extTick = extInputClock != extPrev_q;

	assign srcTick = (clockSource_q == emif_ctl_pkg::SRC_CPU4) ? cpuDiv4Tick :
	                 (clockSource_q == emif_ctl_pkg::SRC_CPU6) ? cpuDiv6Tick : extTick;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] ctrl_q;
	logic        apbAccess;
	logic        ctrlHit;
	logic        statusHit;
	logic [31:0] statusWord;
	logic [31:0] readMux;

	assign apbAccess = psel && penable;
	assign ctrlHit   = paddr == emif_ctl_pkg::CTRL_OFFSET;
	assign statusHit = paddr == emif_ctl_pkg::STATUS_OFFSET;

	// write on the access phase; ready answers in the same cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= emif_ctl_pkg::CTRL_RESET;
		end else if (apbAccess && pready && pwrite && ctrlHit) begin
			ctrl_q <= {27'h0, pwdata[4:0]};
		end
	end

	assign statusWord = {26'h0, clockSource_q, busRequestOut, holdAckOut,
	                     strapTaken_q, sdramClockEnable};
	assign readMux    = ctrlHit ? ctrl_q : (statusHit ? statusWord : 32'h0);

	// registered answer so outputs come from flip-flops; no wait state
	logic readyPend_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			readyPend_q <= 1'b0;
			prdata      <= 32'h0;
			pslverr     <= 1'b0;
		end else begin
			readyPend_q <= psel && !penable;
			prdata      <= readMux;
			pslverr     <= psel && !penable && !ctrlHit && !statusHit;
		end
	end
	assign pready = readyPend_q;

	////////////////////////////////////////////////////////////////////////////////
	// output clocks: a source tick marks each input clock edge, one toggle per tick
	clock_divider u_div (
		.clock   (clock),
		.resetn  (resetn),
		.srcTick (srcTick),
		.divCode (ctrl_q[emif_ctl_pkg::CTRL_DIV_LSB +: 2]),
		.divTick (divTick)
	);

	// the full clock follows every source tick, the second every divided tick
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fullRateOutputClock <= 1'b0;
			dividedOutputClock  <= 1'b0;
		end else begin
			if (srcTick) begin
				fullRateOutputClock <= !fullRateOutputClock;
			end
			if (divTick) begin
				dividedOutputClock <= !dividedOutputClock;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// hold arbitration
	emif_ctl_pkg::arb_state_t arb_q;
	emif_ctl_pkg::arb_state_t arb_d;

	// drain waits for the running access; release only after request drops
	always_comb begin
		arb_d = arb_q;
		case (arb_q)
			emif_ctl_pkg::ARB_OWN: begin
				if (holdReqIn) begin
					arb_d = access.active ? emif_ctl_pkg::ARB_DRAIN : emif_ctl_pkg::ARB_HELD;
				end
			end
			emif_ctl_pkg::ARB_DRAIN: begin
				if (!holdReqIn) begin
					arb_d = emif_ctl_pkg::ARB_OWN; // withdrawn before grant
				end else if (!access.active) begin
					arb_d = emif_ctl_pkg::ARB_HELD;
				end
			end
			emif_ctl_pkg::ARB_HELD: begin
				if (!holdReqIn) begin
					arb_d = emif_ctl_pkg::ARB_OWN;
				end
			end
			default: begin
				arb_d = emif_ctl_pkg::ARB_OWN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			arb_q         <= emif_ctl_pkg::ARB_OWN;
			holdAckOut    <= 1'b0;
			busRequestOut <= 1'b0;
		end else begin
			arb_q         <= arb_d;
			holdAckOut    <= arb_d == emif_ctl_pkg::ARB_HELD;
			busRequestOut <= access.active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared strobe pins, active low
	logic   readLevel;
	logic   outputLevel;
	logic   writeLevel;
	logic   driving;

	// every memory type uses the same three pins; meaning follows the type
	assign readLevel   = (access.memType == emif_ctl_pkg::MEM_SYNC) ?
	                     (access.readSelect ? access.readStrobe : access.active) :
	                     access.readStrobe;
	assign outputLevel = access.outputStrobe;
	assign writeLevel  = access.writeStrobe;
	assign driving     = arb_d == emif_ctl_pkg::ARB_OWN || arb_d == emif_ctl_pkg::ARB_DRAIN;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strobePins <= '1;
			strobeOe   <= 1'b1;
		end else begin
			strobeOe   <= driving;
			strobePins <= access.active ? {!readLevel, !outputLevel, !writeLevel} : 3'h7;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sdram clock enable, or general output when no sdram
	logic cke;
	assign cke = ctrl_q[emif_ctl_pkg::CTRL_SDRAM_BIT] ?
	             !ctrl_q[emif_ctl_pkg::CTRL_SREF_BIT] :
	             ctrl_q[emif_ctl_pkg::CTRL_GPO_BIT];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sdramClockEnable   <= 1'b1;
			sdramClockEnableOe <= 1'b1;
		end else begin
			sdramClockEnable   <= cke;
			sdramClockEnableOe <= driving;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks: arbitration
	a_ack_after_drain: assert property (@(posedge clock) disable iff (!resetn)
		(holdReqIn && !access.active && !holdAckOut) |-> ##[1:2] holdAckOut)
		else $error("hold not acknowledged");
	a_no_ack_idle: assert property (@(posedge clock) disable iff (!resetn)
		(!holdReqIn && !holdAckOut) |=> !holdAckOut)
		else $error("hold granted without request");
	a_no_ack_busy: assert property (@(posedge clock) disable iff (!resetn)
		$rose(holdAckOut) |-> !$past(access.active))
		else $error("hold granted during access");
	a_float_while_held: assert property (@(posedge clock) disable iff (!resetn)
		holdAckOut |-> !strobeOe)
		else $error("bus driven while held");
	a_ack_steady: assert property (@(posedge clock) disable iff (!resetn)
		(holdAckOut && holdReqIn) |=> holdAckOut)
		else $error("hold dropped early");
	a_release_hold: assert property (@(posedge clock) disable iff (!resetn)
		(holdAckOut && !holdReqIn) |=> !holdAckOut)
		else $error("hold not released");
	a_drive_resume: assert property (@(posedge clock) disable iff (!resetn)
		$fell(holdAckOut) |-> strobeOe)
		else $error("bus not driven after hold");
	a_bus_request: assert property (@(posedge clock) disable iff (!resetn)
		access.active |=> busRequestOut)
		else $error("bus request missing");
	a_bus_request_idle: assert property (@(posedge clock) disable iff (!resetn)
		!access.active |=> !busRequestOut)
		else $error("bus request while idle");

	// checks: clock source and output clocks
	a_strap_cpu4: assert property (@(posedge clock) disable iff (!resetn)
		(!strapTaken_q && clockSelectStraps == emif_ctl_pkg::SRC_CPU4)
		|=> clockSource_q == emif_ctl_pkg::SRC_CPU4)
		else $error("cpu4 strap not taken");
	a_strap_cpu6: assert property (@(posedge clock) disable iff (!resetn)
		(!strapTaken_q && clockSelectStraps == emif_ctl_pkg::SRC_CPU6)
		|=> clockSource_q == emif_ctl_pkg::SRC_CPU6)
		else $error("cpu6 strap not taken");
	a_strap_default: assert property (@(posedge clock) disable iff (!resetn)
		(!strapTaken_q && clockSelectStraps != emif_ctl_pkg::SRC_CPU4 &&
		 clockSelectStraps != emif_ctl_pkg::SRC_CPU6) |=> clockSource_q == emif_ctl_pkg::SRC_EXT)
		else $error("external clock not default");
	a_source_kept: assert property (@(posedge clock) disable iff (!resetn)
		strapTaken_q |=> $stable(clockSource_q))
		else $error("clock source changed after reset");
	a_full_clock: assert property (@(posedge clock) disable iff (!resetn)
		srcTick |=> fullRateOutputClock != $past(fullRateOutputClock))
		else $error("full clock missed tick");
	a_full_still: assert property (@(posedge clock) disable iff (!resetn)
		!srcTick |=> $stable(fullRateOutputClock))
		else $error("full clock moved without tick");
	a_div_one: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_q[emif_ctl_pkg::CTRL_DIV_LSB +: 2] == 2'h0 && srcTick)
		|=> dividedOutputClock != $past(dividedOutputClock))
		else $error("divide by one wrong");
	a_div_subset: assert property (@(posedge clock) disable iff (!resetn)
		divTick |-> srcTick)
		else $error("divided tick without source tick");
	a_div_still: assert property (@(posedge clock) disable iff (!resetn)
		!divTick |=> $stable(dividedOutputClock))
		else $error("divided clock moved without tick");

	// checks: shared strobe pins
	a_async_read: assert property (@(posedge clock) disable iff (!resetn)
		(access.active && access.memType == emif_ctl_pkg::MEM_ASYNC)
		|=> strobePins.readPin == !$past(access.readStrobe))
		else $error("async read strobe wrong");
	a_sdram_column: assert property (@(posedge clock) disable iff (!resetn)
		(access.active && access.memType == emif_ctl_pkg::MEM_SDRAM)
		|=> strobePins.readPin == !$past(access.readStrobe))
		else $error("column strobe wrong");
	a_sync_addr: assert property (@(posedge clock) disable iff (!resetn)
		(access.active && access.memType == emif_ctl_pkg::MEM_SYNC && !access.readSelect)
		|=> !strobePins.readPin)
		else $error("address strobe missing");
	a_sync_read: assert property (@(posedge clock) disable iff (!resetn)
		(access.active && access.memType == emif_ctl_pkg::MEM_SYNC && access.readSelect)
		|=> strobePins.readPin == !$past(access.readStrobe))
		else $error("sync read strobe wrong");
	a_output_pin: assert property (@(posedge clock) disable iff (!resetn)
		access.active |=> strobePins.outputPin == !$past(access.outputStrobe))
		else $error("output strobe wrong");
	a_write_pin: assert property (@(posedge clock) disable iff (!resetn)
		access.active |=> strobePins.writePin == !$past(access.writeStrobe))
		else $error("write strobe wrong");
	a_idle_pins: assert property (@(posedge clock) disable iff (!resetn)
		!access.active |=> strobePins == '1)
		else $error("strobe active while idle");

	// checks: clock enable pin
	a_self_refresh: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_q[emif_ctl_pkg::CTRL_SDRAM_BIT] && ctrl_q[emif_ctl_pkg::CTRL_SREF_BIT])
		|=> !sdramClockEnable)
		else $error("cke high in self refresh");
	a_cke_awake: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_q[emif_ctl_pkg::CTRL_SDRAM_BIT] && !ctrl_q[emif_ctl_pkg::CTRL_SREF_BIT])
		|=> sdramClockEnable)
		else $error("cke low outside self refresh");
	a_gpo_follow: assert property (@(posedge clock) disable iff (!resetn)
		!ctrl_q[emif_ctl_pkg::CTRL_SDRAM_BIT]
		|=> sdramClockEnable == $past(ctrl_q[emif_ctl_pkg::CTRL_GPO_BIT]))
		else $error("gpo mismatch");
endmodule

// [verification/hold_requester.sv]
`timescale 1ns/10ps
// external master asking for the memory bus
module hold_requester (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic want,
	output logic      holdReq
);
	// request stays up exactly as long as ownership is wanted
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			holdReq <= 1'b0;
		else
			holdReq <= want;
	end
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} note_t;
	logic                        clock, resetn, psel, penable, pwrite, want;
	logic                        extClk, tick4, tick6, pready, pslverr;
	logic                        fullClk, divClk, holdReq, holdAck, busReq, strobeOe, cke, ckeOe;
	logic                        fPrev, dPrev;
	logic [1:0]                  straps;
	logic [7:0]                  paddr;
	logic [31:0]                 pwdata, prdata;
	emif_ctl_pkg::access_t       acc, accNext;
	emif_ctl_pkg::strobe_pins_t  pins, expPins;
	int                          n_fail, tests_run, t, nf, nd, n0, d0, k, i;
	note_t                       notes[$];
	ext_mem_if_clock_strobe_arb u_dut (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clockSelectStraps(straps), .extInputClock(extClk),
		.cpuDiv4Tick(tick4), .cpuDiv6Tick(tick6), .fullRateOutputClock(fullClk),
		.dividedOutputClock(divClk), .access(acc), .holdReqIn(holdReq), .holdAckOut(holdAck),
		.busRequestOut(busReq), .strobePins(pins), .strobeOe(strobeOe),
		.sdramClockEnable(cke), .sdramClockEnableOe(ckeOe));
	hold_requester u_req (.clock(clock), .resetn(resetn), .want(want), .holdReq(holdReq));
	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// full apb cycle; reads leave their expectation for the monitor
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input note_t n);
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		if (!w) notes.push_back(n);
		@(posedge clock);
		penable <= 1'b1;
		// no own limit: only the watchdog ends a wait for pready
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task do_reset;
		@(posedge clock);
		resetn <= 1'b0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
	endtask
	task wait_check(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// read data taken only at the edge that completes the access
	always @(posedge clock) if (psel && penable && pready === 1'b1 && !pwrite) begin
		check(prdata & notes[0].mask, notes[0].exp, "read data");
		check(pslverr, notes[0].err, "slave error");
		void'(notes.pop_front());
	end
	// source ticks at three unrelated rates; toggle counters on both outputs
	always @(posedge clock) begin
		t <= t + 1;
		tick4 <= (t % 4 == 0);
		tick6 <= (t % 6 == 0);
		if (t % 5 == 0) extClk <= ~extClk;
		fPrev <= fullClk; dPrev <= divClk;
		nf <= nf + (fullClk != fPrev);
		nd <= nd + (divClk != dPrev);
	end
	initial begin clock = 0; forever #50 clock = ~clock; end
	// hang guard, far past the expected run length
	initial begin #2ms; n_fail++; print_verdict(); end
	initial begin
		{resetn, psel, penable, pwrite, want, extClk, tick4, tick6, fPrev, dPrev} = '0;
		{paddr, pwdata, straps, acc, n_fail, tests_run, t, nf, nd} = '0;
		void'($urandom(95));
		// strap choice, full rate and divided rate for each source
		for (i = 0; i < 3; i++) begin
			@(posedge clock);
			straps <= i[1:0];
			do_reset();
			apb(1'b1, emif_ctl_pkg::CTRL_OFFSET, i, '{0, 0, 0});
			apb(1'b0, emif_ctl_pkg::STATUS_OFFSET, 0, '{{i[1:0], 4'h2}, 32'h3e, 0});
			wait_check(1); n0 = nf; d0 = nd;
			wait_check(240);
			k = (i == 0) ? 48 : (i == 1) ? 60 : 40;
			check((nf - n0 - k) inside {[-1:1]}, 1'b1, "full rate");
			check((nd - d0 - k / (1 << i)) inside {[-1:1]}, 1'b1, "divided");
			$display("clock source %0d done", i);
		end
		// strobe pins follow the memory type of a random access
		for (i = 0; i < 12; i++) begin
			@(posedge clock);
			accNext = 7'($urandom);
			accNext.active = 1'b1;
			accNext.memType = emif_ctl_pkg::mem_type_t'(i % 3);
			acc <= accNext;
			wait_check(2);
			expPins.readPin = (acc.memType == emif_ctl_pkg::MEM_SYNC && !acc.readSelect) ?
				1'b0 : ~acc.readStrobe;
			expPins.outputPin = ~acc.outputStrobe;
			expPins.writePin = ~acc.writeStrobe;
			check(pins, expPins, "strobes");
			check(busReq, 1'b1, "bus request");
		end
		$display("strobe test done");
		// hold asked mid-access waits, then floats the bus, then gives it back
		@(posedge clock); want <= 1'b1;
		wait_check(4); check(holdAck, 1'b0, "early ack");
		@(posedge clock); acc.active <= 1'b0;
		wait_check(4); check({holdAck, strobeOe}, 2'b10, "hold granted");
		check(ckeOe, 1'b0, "cke floated");
		@(posedge clock); want <= 1'b0;
		wait_check(3); check({holdAck, strobeOe}, 2'b01, "hold released");
		$display("hold test done");
		// clock enable: self refresh with sdram, general output without
		apb(1'b1, emif_ctl_pkg::CTRL_OFFSET, 32'h18, '{0, 0, 0});
		wait_check(2); check({cke, ckeOe}, 2'b11, "cke on");
		apb(1'b1, emif_ctl_pkg::CTRL_OFFSET, 32'h14, '{0, 0, 0});
		wait_check(2); check(cke, 1'b0, "self refresh");
		apb(1'b0, emif_ctl_pkg::CTRL_OFFSET, 0, '{32'h14, 32'hffffffff, 0});
		apb(1'b1, emif_ctl_pkg::CTRL_OFFSET, 32'h08, '{0, 0, 0});
		wait_check(2); check(cke, 1'b1, "gpo high");
		apb(1'b1, emif_ctl_pkg::CTRL_OFFSET, 32'h00, '{0, 0, 0});
		wait_check(2); check(cke, 1'b0, "gpo low");
		apb(1'b0, 8'h08, 0, '{0, 32'hffffffff, 1});
		wait_check(2);
		$display("clock enable test done");
		print_verdict();
	end
endmodule
